// >>> rtl/ser_status_top.sv
// Status byte, event, operation and error reporting of the instrument
`timescale 1ns/10ps
module ser_status_top #(
	parameter int unsigned ERR_DEPTH = ser_pkg::ERR_DEPTH
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic cmdValid,
	input wire ser_pkg::ser_cmd_t cmdCode,
	input wire logic [7:0] cmdData,
	input wire logic rspRead,
	input wire logic execIdle,
	input wire logic devErr,
	input wire logic execErr,
	input wire logic cmdErr,
	input wire logic [ser_pkg::ERR_W-1:0] errCode,
	input wire logic localSwitch,
	input wire logic calibrating,
	input wire logic sweeping,
	input wire logic spollReq,
	output logic rspPending,
	output logic rspNeg,
	output logic [ser_pkg::BCD_W-1:0] rspBcd,
	output logic spollValid,
	output logic [7:0] spollByte,
	output logic srq
);
	import ser_pkg::*;

	typedef enum logic [0:0] {
		ST_IDLE,
		ST_ERRWAIT
	} ser_state_e;

	typedef struct packed {
		ser_state_e st;
		logic [7:0] event_status_flags;
		logic [7:0] event_status_mask;
		logic [7:0] sre;
		logic [15:0] opCond;
		logic [15:0] opEv;
		logic opcPend;
		logic rspPending;
		logic rspNeg;
		logic [BCD_W-1:0] rspBcd;
		logic spollValid;
		logic [7:0] spollByte;
		logic srq;
	} ser_state_s;

	ser_state_s s_q;
	ser_state_s s_d;
	ser_err_if #(.W(ERR_W)) errQ ();

	logic [7:0] stbNow;
	logic reqNow;
	logic [15:0] condNow;
	logic cmdTaken;

	ser_err_mem #(.DEPTH(ERR_DEPTH), .W(ERR_W)) u_mem (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.port(errQ.mem)
	);

	// ************************************************************
	// Status byte and request summary
	// ************************************************************
	always_comb begin
		stbNow = '0;
		stbNow[STB_ERQ] = !errQ.empty;
		stbNow[STB_MAV] = s_q.rspPending;
		stbNow[STB_ESB] = |(s_q.event_status_flags & s_q.event_status_mask & ESR_USED);
		// Only bits 2, 4 and 5 can request; mask bit 6 never enters
		reqNow = |(stbNow & s_q.sre & SRQ_SRC);
		stbNow[STB_MSS] = reqNow;
	end

	always_comb begin
		condNow = '0;
		condNow[OPER_CAL] = calibrating;
		condNow[OPER_SWP] = sweeping;
	end

	assign cmdTaken = cmdValid && (s_q.st == ST_IDLE);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		logic [7:0] esrSet;
		logic esrClr;
		logic opEvClr;
		logic pendNow;
		logic qryErr;
		logic [ERR_W-1:0] val;
		logic isQuery;
		esrSet = '0;
		pendNow = 1'b0;
		esrClr = 1'b0;
		opEvClr = 1'b0;
		qryErr = 1'b0;
		val = '0;
		isQuery = 1'b0;
		s_d = s_q;
		s_d.spollValid = 1'b0;
		errQ.push = 1'b0;
		errQ.pushData = ERR_NONE;
		errQ.pop = 1'b0;
		errQ.clr = 1'b0;

		// Reading a response that was never asked for
		pendNow = s_q.rspPending;
		if (rspRead) begin
			if (!s_q.rspPending) begin
				qryErr = 1'b1;
			end
			pendNow = 1'b0;
		end

		if (cmdTaken) begin
			// New command while an answer is unread: answer is lost
			if (pendNow) begin
				qryErr = 1'b1;
				pendNow = 1'b0;
			end
			case (cmdCode)
				CMD_ESE_SET: s_d.event_status_mask = cmdData;
				CMD_SRE_SET: s_d.sre = cmdData;
				CMD_ESE_Q: begin
					val = {8'h00, s_q.event_status_mask};
					isQuery = 1'b1;
				end
				CMD_SRE_Q: begin
					val = {8'h00, s_q.sre};
					isQuery = 1'b1;
				end
				CMD_ESR_Q: begin
					val = {8'h00, s_q.event_status_flags & ESR_USED};
					esrClr = 1'b1;
					isQuery = 1'b1;
				end
				CMD_STB_Q: begin
					val = {8'h00, stbNow};
					isQuery = 1'b1;
				end
				CMD_OPC: s_d.opcPend = 1'b1;
				CMD_QCOND_Q, CMD_QEVEN_Q: begin
					val = QUES_USED;
					isQuery = 1'b1;
				end
				CMD_OCOND_Q: begin
					val = s_q.opCond & OPER_USED;
					isQuery = 1'b1;
				end
				CMD_OEVEN_Q: begin
					val = s_q.opEv & OPER_USED;
					opEvClr = 1'b1;
					isQuery = 1'b1;
				end
				CMD_ERR_Q: begin
					// Empty queue answers code 0 at once
					if (errQ.empty) begin
						val = ERR_NONE;
						isQuery = 1'b1;
					end else begin
						errQ.pop = 1'b1;
						s_d.st = ST_ERRWAIT;
					end
				end
				CMD_CLS: begin
					esrClr = 1'b1;
					opEvClr = 1'b1;
					errQ.clr = 1'b1;
					s_d.opcPend = 1'b0;
				end
				default: begin
				end
			endcase
		end

		// Popped entry arrives one cycle after the pop
		if (s_q.st == ST_ERRWAIT) begin
			val = errQ.popData;
			isQuery = 1'b1;
			s_d.st = ST_IDLE;
		end

		if (isQuery) begin
			s_d.rspNeg = val[ERR_W-1];
			// Magnitude goes to the decimal digits, sign stands apart
			s_d.rspBcd = ser_to_bcd(val[ERR_W-1] ? (~val) + 16'h0001 : val);
			pendNow = 1'b1;
		end
		s_d.rspPending = pendNow;

		// Completion waits for every earlier command
		if (s_q.opcPend && execIdle) begin
			esrSet[ESR_OPC] = 1'b1;
			s_d.opcPend = 1'b0;
		end
		esrSet[ESR_QRY] = qryErr;
		esrSet[ESR_DEV] = devErr;
		esrSet[ESR_EXE] = execErr;
		esrSet[ESR_CMD] = cmdErr;
		esrSet[ESR_USR] = localSwitch;

		// One entry per cycle; the queue clear loses to a new error
		if (cmdErr || execErr || devErr) begin
			errQ.push = 1'b1;
			errQ.pushData = errCode;
			errQ.clr = 1'b0;
		end else if (qryErr) begin
			errQ.push = 1'b1;
			errQ.pushData = ERR_QUERY;
			errQ.clr = 1'b0;
		end

		// Set beats clear on every flag
		s_d.event_status_flags = ((esrClr ? 8'h00 : s_q.event_status_flags) | esrSet) & ESR_USED;
		s_d.opCond = condNow;
		s_d.opEv = ((opEvClr ? 16'h0000 : s_q.opEv) | (condNow & ~s_q.opCond)) & OPER_USED;

		if (spollReq) begin
			s_d.spollValid = 1'b1;
			s_d.spollByte = stbNow;
		end
		s_d.srq = reqNow;
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.event_status_flags <= ESR_RST;
			s_q.event_status_mask <= ESE_RST;
			s_q.sre <= SRE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign rspPending = s_q.rspPending;
	assign rspNeg = s_q.rspNeg;
	assign rspBcd = s_q.rspBcd;
	assign spollValid = s_q.spollValid;
	assign spollByte = s_q.spollByte;
	assign srq = s_q.srq;

	// ************************************************************
	// Checks
	// ************************************************************
	a_opc_done: assert property (@(posedge mclk) disable iff (sys_rst)
		(s_q.opcPend && execIdle) |=> s_q.event_status_flags[ESR_OPC] && !s_q.opcPend)
		else $error("completion flag not set");
	a_opc_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		(s_q.opcPend && !execIdle && !s_q.event_status_flags[ESR_OPC] && !cmdValid) |=> !s_q.event_status_flags[ESR_OPC])
		else $error("completion flag set early");
	a_query_err: assert property (@(posedge mclk) disable iff (sys_rst)
		(rspRead && !s_q.rspPending) |=> s_q.event_status_flags[ESR_QRY])
		else $error("query error missed");
	a_cmd_err: assert property (@(posedge mclk) disable iff (sys_rst)
		cmdErr |=> s_q.event_status_flags[ESR_CMD] && !errQ.empty)
		else $error("command error not recorded");
	a_exe_err: assert property (@(posedge mclk) disable iff (sys_rst)
		execErr |=> s_q.event_status_flags[ESR_EXE] && !errQ.empty)
		else $error("execution error not recorded");
	a_dev_err: assert property (@(posedge mclk) disable iff (sys_rst)
		devErr |=> s_q.event_status_flags[ESR_DEV] && !errQ.empty)
		else $error("device error not recorded");
	a_user_req: assert property (@(posedge mclk) disable iff (sys_rst)
		localSwitch |=> s_q.event_status_flags[ESR_USR])
		else $error("user request flag missed");
	a_cal_cond: assert property (@(posedge mclk) disable iff (sys_rst)
		##1 s_q.opCond[OPER_CAL] == $past(calibrating))
		else $error("calibration bit wrong");
	a_swp_event: assert property (@(posedge mclk) disable iff (sys_rst)
		(sweeping && !s_q.opCond[OPER_SWP]) |=> s_q.opEv[OPER_SWP] && s_q.opCond[OPER_SWP])
		else $error("sweep event missed");
	a_srq_out: assert property (@(posedge mclk) disable iff (sys_rst)
		##1 srq == $past(|(stbNow & s_q.sre & SRQ_SRC)))
		else $error("service request wrong");
	a_srq_mask6: assert property (@(posedge mclk) disable iff (sys_rst)
		(s_q.sre[STB_MSS] && !(|(stbNow & s_q.sre & SRQ_SRC))) |=> !srq)
		else $error("mask bit 6 raised request");
	a_spoll_byte: assert property (@(posedge mclk) disable iff (sys_rst)
		spollReq |=> spollValid && spollByte[STB_ERQ] == $past(!errQ.empty))
		else $error("serial poll byte wrong");
	a_unused_zero: assert property (@(posedge mclk) disable iff (sys_rst)
		((s_q.opEv & ~OPER_USED) == 16'h0000) && ((s_q.event_status_flags & ~ESR_USED) == 8'h00))
		else $error("unused bit set");
	a_err_empty: assert property (@(posedge mclk) disable iff (sys_rst)
		(cmdTaken && cmdCode == CMD_ERR_Q && errQ.empty) |=> rspPending && rspBcd == '0)
		else $error("empty queue answer wrong");

	// ************************************************************
	// Checks of masks, answers, serial poll, operation status and queue clear
	// ************************************************************
	a_esb_poll: assert property (@(posedge mclk) disable iff (sys_rst)
		(spollReq && (|(s_q.event_status_flags & s_q.event_status_mask))) |=> spollByte[STB_ESB])
		else $error("event summary missing in poll");
	a_mss_poll: assert property (@(posedge mclk) disable iff (sys_rst)
		spollReq |=> spollByte[STB_MSS] == (|(spollByte & $past(s_q.sre) & SRQ_SRC)))
		else $error("request summary wrong in poll");
	a_mav_poll: assert property (@(posedge mclk) disable iff (sys_rst)
		spollReq |=> spollByte[STB_MAV] == $past(s_q.rspPending))
		else $error("answer bit wrong in poll");
	a_poll_unused: assert property (@(posedge mclk) disable iff (sys_rst)
		spollValid |-> (spollByte & ~SRQ_SRC & ~(8'h01 << STB_MSS)) == 8'h00)
		else $error("unused status byte bit set");
	a_ese_write: assert property (@(posedge mclk) disable iff (sys_rst)
		(cmdTaken && cmdCode == CMD_ESE_SET) |=> s_q.event_status_mask == $past(cmdData))
		else $error("event mask not written");
	a_ese_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		!(cmdTaken && cmdCode == CMD_ESE_SET) |=> $stable(s_q.event_status_mask))
		else $error("event mask changed");
	a_sre_write: assert property (@(posedge mclk) disable iff (sys_rst)
		(cmdTaken && cmdCode == CMD_SRE_SET) |=> s_q.sre == $past(cmdData))
		else $error("request mask not written");
	a_esr_answer: assert property (@(posedge mclk) disable iff (sys_rst)
		(cmdTaken && cmdCode == CMD_ESR_Q) |=> rspPending && !rspNeg
		&& rspBcd[BCD_W-1:BCD_W-8] == 8'h00)
		else $error("event flag answer wrong");
	a_err_pop: assert property (@(posedge mclk) disable iff (sys_rst)
		(cmdTaken && cmdCode == CMD_ERR_Q && !errQ.empty) |=> s_q.st == ST_ERRWAIT ##1 rspPending)
		else $error("queue entry not answered");
	a_opev_accum: assert property (@(posedge mclk) disable iff (sys_rst)
		(s_q.opEv[OPER_CAL] && !(cmdTaken && (cmdCode == CMD_OEVEN_Q || cmdCode == CMD_CLS)))
		|=> s_q.opEv[OPER_CAL])
		else $error("operation event lost");
	a_swp_cond: assert property (@(posedge mclk) disable iff (sys_rst)
		##1 s_q.opCond[OPER_SWP] == $past(sweeping))
		else $error("sweep bit wrong");
	a_opev_clear: assert property (@(posedge mclk) disable iff (sys_rst)
		(cmdTaken && cmdCode == CMD_OEVEN_Q && !calibrating && !sweeping) |=> s_q.opEv == 16'h0000)
		else $error("operation event not cleared");
	a_ques_zero: assert property (@(posedge mclk) disable iff (sys_rst)
		(cmdTaken && (cmdCode == CMD_QCOND_Q || cmdCode == CMD_QEVEN_Q))
		|=> rspPending && !rspNeg && rspBcd == '0)
		else $error("questionable answer not zero");
	a_cls_clear: assert property (@(posedge mclk) disable iff (sys_rst)
		(cmdTaken && cmdCode == CMD_CLS && !s_q.rspPending && !rspRead
		&& !(cmdErr || execErr || devErr)) |=> errQ.empty)
		else $error("queue not cleared");

endmodule : ser_status_top

// >>> rtl/ser_pkg.sv
// Constants, types and helpers of the status event reporting block
package ser_pkg;

	localparam int unsigned ERR_W = 16;
	localparam int unsigned BCD_W = 20;
	localparam int unsigned ERR_DEPTH = 16;

	// Event flag positions
	localparam int unsigned ESR_OPC = 0;
	localparam int unsigned ESR_QRY = 2;
	localparam int unsigned ESR_DEV = 3;
	localparam int unsigned ESR_EXE = 4;
	localparam int unsigned ESR_CMD = 5;
	localparam int unsigned ESR_USR = 6;
	localparam int unsigned ESR_PON = 7;

	// Status byte positions
	localparam int unsigned STB_ERQ = 2;
	localparam int unsigned STB_MAV = 4;
	localparam int unsigned STB_ESB = 5;
	localparam int unsigned STB_MSS = 6;

	// Operation status positions
	localparam int unsigned OPER_CAL = 0;
	localparam int unsigned OPER_SWP = 3;

	localparam logic [7:0] ESR_RST = 8'h80;
	localparam logic [7:0] ESE_RST = 8'h00;
	localparam logic [7:0] SRE_RST = 8'h00;
	localparam logic [7:0] ESR_USED = 8'hFD;
	localparam logic [7:0] SRQ_SRC = 8'h34;
	localparam logic [15:0] OPER_USED = 16'h0009;
	localparam logic [15:0] QUES_USED = 16'h0000;
	localparam logic [ERR_W-1:0] ERR_NONE = 16'h0000;
	// Query error code, -410
	localparam logic [ERR_W-1:0] ERR_QUERY = 16'hFE66;

	typedef logic [3:0] ser_cmd_t;
	localparam ser_cmd_t CMD_ESE_SET = 4'h0;
	localparam ser_cmd_t CMD_ESE_Q = 4'h1;
	localparam ser_cmd_t CMD_ESR_Q = 4'h2;
	localparam ser_cmd_t CMD_SRE_SET = 4'h3;
	localparam ser_cmd_t CMD_SRE_Q = 4'h4;
	localparam ser_cmd_t CMD_STB_Q = 4'h5;
	localparam ser_cmd_t CMD_OPC = 4'h6;
	localparam ser_cmd_t CMD_QCOND_Q = 4'h7;
	localparam ser_cmd_t CMD_QEVEN_Q = 4'h8;
	localparam ser_cmd_t CMD_OCOND_Q = 4'h9;
	localparam ser_cmd_t CMD_OEVEN_Q = 4'hA;
	localparam ser_cmd_t CMD_ERR_Q = 4'hB;
	localparam ser_cmd_t CMD_CLS = 4'hC;

	// Binary to packed decimal digits, shift and add three
	function automatic logic [BCD_W-1:0] ser_to_bcd(input logic [ERR_W-1:0] bin);
		logic [BCD_W-1:0] bcd;
		bcd = '0;
		for (int i = ERR_W - 1; i >= 0; i--) begin
			for (int d = 0; d < BCD_W / 4; d++) begin
				if (bcd[d*4 +: 4] > 4'h4) begin
					bcd[d*4 +: 4] = bcd[d*4 +: 4] + 4'h3;
				end
			end
			bcd = {bcd[BCD_W-2:0], bin[i]};
		end
		return bcd;
	endfunction : ser_to_bcd

endpackage : ser_pkg

// >>> rtl/ser_err_if.sv
// Link between the status logic and its error queue memory
`timescale 1ns/10ps
interface ser_err_if #(parameter int unsigned W = 16);
	logic push;
	logic [W-1:0] pushData;
	logic pop;
	logic clr;
	logic [W-1:0] popData;
	logic empty;
	logic full;
	modport ctrl (output push, pushData, pop, clr, input popData, empty, full);
	modport mem (input push, pushData, pop, clr, output popData, empty, full);
endinterface : ser_err_if

// >>> rtl/ser_err_mem.sv
// Error queue storage with registered read data
`timescale 1ns/10ps
module ser_err_mem #(
	parameter int unsigned DEPTH = 16,
	parameter int unsigned W = 16
) (
	input wire logic mclk,
	input wire logic sys_rst,
	ser_err_if.mem port
);
	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] data;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
		logic [W-1:0] rdData;
	} ser_mem_s;

	ser_mem_s s_q;
	ser_mem_s s_d;
	logic doPush;
	logic doPop;

	// A full queue drops new entries; the oldest causes stay readable
	assign doPush = port.push && (s_q.cnt != (AW+1)'(DEPTH));
	assign doPop = port.pop && (s_q.cnt != '0);
	assign port.popData = s_q.rdData;
	assign port.empty = (s_q.cnt == '0);
	assign port.full = (s_q.cnt == (AW+1)'(DEPTH));

	always_comb begin
		s_d = s_q;
		if (doPush) begin
			s_d.data[s_q.wr] = port.pushData;
			s_d.wr = s_q.wr + 1'b1;
		end
		if (doPop) begin
			s_d.rdData = s_q.data[s_q.rd];
			s_d.rd = s_q.rd + 1'b1;
		end
		s_d.cnt = s_q.cnt + (AW+1)'(doPush) - (AW+1)'(doPop);
		if (port.clr) begin
			s_d.wr = '0;
			s_d.rd = '0;
			s_d.cnt = '0;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : ser_err_mem

// >>> bench/ser_ctrl_model.sv
// Remote controller model: commands, answer reads, serial polls
`timescale 1ns/10ps
module ser_ctrl_model
	import ser_pkg::*;
(
	input wire logic mclk,
	input wire logic rspPending,
	input wire logic rspNeg,
	input wire logic [ser_pkg::BCD_W-1:0] rspBcd,
	input wire logic spollValid,
	input wire logic [7:0] spollByte,
	output logic cmdValid,
	output ser_pkg::ser_cmd_t cmdCode,
	output logic [7:0] cmdData,
	output logic rspRead,
	output logic spollReq
);
	// ****
	// Bus side
	// ****
	initial begin
		cmdValid = 1'b0;
		cmdCode = CMD_CLS;
		cmdData = 8'h00;
		rspRead = 1'b0;
		spollReq = 1'b0;
	end
	// Mask value rides with the strobe
	task send(input ser_cmd_t c, input logic [7:0] d);
		@(posedge mclk);
		cmdValid <= 1'b1;
		cmdCode <= c;
		cmdData <= d;
		@(posedge mclk);
		cmdValid <= 1'b0;
		cmdData <= ~d;
	endtask : send
	task rd();
		@(posedge mclk);
		rspRead <= 1'b1;
		@(posedge mclk);
		rspRead <= 1'b0;
	endtask : rd
	// Waits a bounded time, a missing answer reads as unknown
	task ask(input ser_cmd_t c, output logic n, output logic [BCD_W-1:0] v);
		send(c, 8'h00);
		#1;
		for (int i = 0; i < 3 && rspPending !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
		end
		n = (rspPending === 1'b1) ? rspNeg : 1'bx;
		v = (rspPending === 1'b1) ? rspBcd : 'x;
		rd();
	endtask : ask
	// Status byte comes back one cycle after the poll
	task poll(output logic [7:0] b);
		@(posedge mclk);
		spollReq <= 1'b1;
		@(posedge mclk);
		spollReq <= 1'b0;
		#1;
		b = (spollValid === 1'b1) ? spollByte : 8'hxx;
	endtask : poll
endmodule : ser_ctrl_model

// >>> bench/status_event_reporting_tb.sv
// Self-checking bench of the status event reporting block
`timescale 1ns/10ps
module status_event_reporting_tb;
	import ser_pkg::*;
	// ****
	// Harness
	// ****
	logic mclk, sys_rst, execIdle, devErr, execErr, cmdErr, localSwitch, calibrating, sweeping;
	logic cmdValid, rspRead, spollReq, rspPending, rspNeg, spollValid, srq, n;
	logic [ERR_W-1:0] errCode;
	ser_cmd_t cmdCode;
	logic [7:0] cmdData, spollByte, b;
	logic [BCD_W-1:0] rspBcd, v;
	int err_total, n_checks, cycles;
	ser_status_top #(.ERR_DEPTH(ERR_DEPTH)) i_ser_status_top (.mclk(mclk), .sys_rst(sys_rst),
		.cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData), .rspRead(rspRead),
		.execIdle(execIdle), .devErr(devErr), .execErr(execErr), .cmdErr(cmdErr),
		.errCode(errCode), .localSwitch(localSwitch), .calibrating(calibrating),
		.sweeping(sweeping), .spollReq(spollReq), .rspPending(rspPending), .rspNeg(rspNeg),
		.rspBcd(rspBcd), .spollValid(spollValid), .spollByte(spollByte), .srq(srq));
	ser_ctrl_model i_ser_ctrl_model (.mclk(mclk), .rspPending(rspPending), .rspNeg(rspNeg),
		.rspBcd(rspBcd), .spollValid(spollValid), .spollByte(spollByte), .cmdValid(cmdValid),
		.cmdCode(cmdCode), .cmdData(cmdData), .rspRead(rspRead), .spollReq(spollReq));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// Sign flag above five decimal digits
	function automatic logic [23:0] ex(input int x);
		logic [23:0] r;
		int m;
		r = '0;
		m = (x < 0) ? -x : x;
		r[20] = (x < 0);
		for (int d = 0; d < 5; d++) begin
			r[d*4 +: 4] = 4'(m % 10);
			m = m / 10;
		end
		return r;
	endfunction : ex
	task chk(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task q(input ser_cmd_t c, input int x);
		i_ser_ctrl_model.ask(c, n, v);
		chk({3'b000, n, v}, ex(x));
	endtask : q
	task w(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : w
	task err(input int k, input int x);
		@(posedge mclk);
		errCode <= x[ERR_W-1:0];
		cmdErr <= (k == 0);
		execErr <= (k == 1);
		devErr <= (k == 2);
		localSwitch <= (k == 3);
		@(posedge mclk);
		{cmdErr, execErr, devErr, localSwitch} <= 4'h0;
	endtask : err
	// ****
	// Scenarios
	// ****
	task t_power();
		q(CMD_ESR_Q, 128);
		q(CMD_ESR_Q, 0);
		q(CMD_ESE_Q, 0);
		q(CMD_QCOND_Q, 0);
	endtask : t_power
	task t_opc();
		@(posedge mclk);
		execIdle <= 1'b0;
		i_ser_ctrl_model.send(CMD_ESE_SET, 8'h01);
		i_ser_ctrl_model.send(CMD_SRE_SET, 8'h20);
		i_ser_ctrl_model.send(CMD_OPC, 8'h00);
		w(6);
		chk(srq, 1'b0);
		@(posedge mclk);
		execIdle <= 1'b1;
		w(4);
		chk(srq, 1'b1);
		i_ser_ctrl_model.poll(b);
		chk(b, 8'h60);
		q(CMD_ESR_Q, 1);
		w(3);
		chk(srq, 1'b0);
	endtask : t_opc
	task t_err();
		i_ser_ctrl_model.send(CMD_SRE_SET, 8'h04);
		err(0, -150);
		err(1, -250);
		err(2, -350);
		err(2, 300);
		w(3);
		chk(srq, 1'b1);
		i_ser_ctrl_model.poll(b);
		chk(b, 8'h44);
		q(CMD_ESR_Q, 56);
		q(CMD_ERR_Q, -150);
		q(CMD_ERR_Q, -250);
		q(CMD_ERR_Q, -350);
		q(CMD_ERR_Q, 300);
		q(CMD_ERR_Q, 0);
		chk(srq, 1'b0);
	endtask : t_err
	// Unread answer overrun, then a read with nothing pending
	task t_qry();
		i_ser_ctrl_model.send(CMD_ESE_Q, 8'h00);
		i_ser_ctrl_model.send(CMD_SRE_SET, 8'h00);
		q(CMD_ESR_Q, 4);
		q(CMD_ERR_Q, -410);
		i_ser_ctrl_model.rd();
		q(CMD_ESR_Q, 4);
		i_ser_ctrl_model.send(CMD_CLS, 8'h00);
		q(CMD_ERR_Q, 0);
	endtask : t_qry
	task t_loc();
		i_ser_ctrl_model.send(CMD_ESE_SET, 8'hFF);
		i_ser_ctrl_model.send(CMD_SRE_SET, 8'h40);
		q(CMD_ESE_Q, 255);
		err(3, 0);
		w(3);
		chk(srq, 1'b0);
		i_ser_ctrl_model.poll(b);
		chk(b, 8'h20);
		i_ser_ctrl_model.send(CMD_SRE_SET, 8'hFF);
		w(3);
		chk(srq, 1'b1);
		q(CMD_SRE_Q, 255);
		q(CMD_STB_Q, 96);
		q(CMD_ESR_Q, 64);
	endtask : t_loc
	task t_op();
		@(posedge mclk);
		calibrating <= 1'b1;
		sweeping <= 1'b1;
		w(2);
		q(CMD_OCOND_Q, 9);
		@(posedge mclk);
		calibrating <= 1'b0;
		w(2);
		q(CMD_OCOND_Q, 8);
		@(posedge mclk);
		sweeping <= 1'b0;
		w(2);
		q(CMD_OCOND_Q, 0);
		q(CMD_OEVEN_Q, 9);
		q(CMD_OEVEN_Q, 0);
		q(CMD_QEVEN_Q, 0);
	endtask : t_op
	// ****
	// Run control
	// ****
	task finish_test();
		$display("Checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test
	// Whole run needs well under a thousand cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			finish_test();
		end
	end
	initial begin
		{sys_rst, execIdle} = 2'b11;
		{devErr, execErr, cmdErr, localSwitch, calibrating, sweeping} = 6'h00;
		errCode = '0;
		err_total = 0;
		n_checks = 0;
		cycles = 0;
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		t_power();
		t_opc();
		t_err();
		t_qry();
		t_loc();
		t_op();
		finish_test();
	end
endmodule : status_event_reporting_tb
